// ==== src/sps_pkg.sv ====
package sps_pkg;

    // Register map of the slice, byte addresses on the register bus.
    localparam logic [3:0]  OFS_PIN_STATE = 4'h0;
    localparam logic [31:0] PIN_STATE_RST = 32'h0000_0000;

    // Number of serial pins held in this slice and the lowest bit used.
    localparam int NUM_PINS  = 9;
    localparam int FIRST_BIT = 13;

    // Bit positions of each pin within the pin state register.
    localparam int BIT_P1_RX    = 13;
    localparam int BIT_P2_TX    = 14;
    localparam int BIT_P2_RX    = 15;
    localparam int BIT_P3_TX    = 16;
    localparam int BIT_P3_RX    = 17;
    localparam int BIT_P4_TX    = 18;
    localparam int BIT_P4_RX    = 19;
    localparam int BIT_P4_CLK   = 20;
    localparam int BIT_P4_FRAME = 21;

    // Reset values of the stored write value and the pin synchronisers.
    localparam logic STORE_RST = 1'b0;
    localparam logic SYNC_RST  = 1'b0;

    // Bus answer state machine.
    typedef enum logic [0:0] {
        BUS_IDLE   = 1'b0,
        BUS_ANSWER = 1'b1
    } sps_bus_st_t;

endpackage

// ==== src/sps_sync3.sv ====
`timescale 1ns/1ps
`default_nettype none

module sps_sync3 (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_n,
    // Asynchronous pin level in, filtered level out.
    input  wire logic async_in,
    output logic      level
);

    logic stage1_q;
    logic stage2_q;
    logic stage3_q;
    logic level_q;

    // Three stages; only the second stage reads the first, so the first
    // may go metastable without any logic ever seeing it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_q <= sps_pkg::SYNC_RST;
            stage2_q <= sps_pkg::SYNC_RST;
            stage3_q <= sps_pkg::SYNC_RST;
        end else begin
            stage1_q <= async_in;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    // A change counts only once the second and third stages agree.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_q <= sps_pkg::SYNC_RST;
        end else if (stage2_q == stage3_q) begin
            level_q <= stage3_q;
        end
    end

    assign level = level_q;

endmodule // sps_sync3

`default_nettype wire

// ==== src/sps_pin_cell.sv ====
`timescale 1ns/1ps
`default_nettype none

module sps_pin_cell (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_n,
    // Write strobe and written level from the register bus.
    input  wire logic wr_en,
    input  wire logic wr_val,
    // High while the owning unit is disabled and the pin is an output.
    input  wire logic may_drive,
    // Stored value and pin drive.
    output logic      store,
    output logic      pin_out,
    output logic      pin_oe
);

    logic store_q;
    logic oe_q;

    // The written value is always kept, even while it cannot reach the pin,
    // so software can preload a level before it releases the unit.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            store_q <= sps_pkg::STORE_RST;
        end else if (wr_en) begin
            store_q <= wr_val;
        end
    end

    // The drive enable is registered so the pad sees no decode glitches.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= may_drive;
        end
    end

    assign store   = store_q;
    assign pin_out = store_q;
    assign pin_oe  = oe_q;

endmodule // sps_pin_cell

`default_nettype wire

// ==== src/sps_pin_state.sv ====
// What this block does
// - Bit 13 reads back the live level of the port 1 receive pin.
// - A write to bit 13 drives the port 1 receive pin only while port 1's receiver is off and the pin is an output.
// - Bit 14 reads the port 2 transmit pin and a write drives it only while port 2's transmitter is off and the pin is an output.
// - Bit 15 reads back the live level of the port 2 receive pin.
// - A write to bit 15 drives the port 2 receive pin only while port 2's receiver is off and the pin is an output.
// - The port 3 transmit bit reads the pin and a write drives it only while port 3's transmitter is off and the pin is an output.
// - The port 3 receive bit reads the pin and a write drives it only while port 3's receiver is off and the pin is an output.
// - The port 4 transmit bit reads the pin and a write drives it only while port 4's transmitter is off and the pin is an output.
// - The port 4 receive bit reads the pin and a write drives it only while port 4's receive path is off and the pin is an output.
// - The port 4 clock bit reads the pin and a write drives it only while port 4 is off and the pin is an output.
// - The port 4 frame bit reads the pin and a write drives it only while port 4 is off and the pin is an output.
// - The port 4 transmit pin state sits at bit 18.
// - The port 4 receive pin state sits at bit 19.
// - The port 4 clock pin state sits at bit 20.
// - The port 4 frame pin state sits at bit 21.
`timescale 1ns/1ps
`default_nettype none

module sps_pin_state (
    // Clock and asynchronous active-low reset.
    input  wire logic        clk,
    input  wire logic        nrst,

    // Avalon-MM slave.
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,

    // Unit enables from the serial units, same clock.
    input  wire logic        port1_rx_en,
    input  wire logic        port2_tx_en,
    input  wire logic        port2_rx_en,
    input  wire logic        port3_tx_en,
    input  wire logic        port3_rx_en,
    input  wire logic        port4_tx_en,
    input  wire logic        port4_rx_en,
    input  wire logic        port4_en,

    // Direction bits 13 to 21 from the direction register, 1 is output.
    input  wire logic [8:0]  pin_dir_out,

    // Pad side of the nine pins, index is bit number minus 13.
    input  wire logic [8:0]  pin_in,
    output logic      [8:0]  pin_out,
    output logic      [8:0]  pin_oe
);

    localparam int N = sps_pkg::NUM_PINS;

    // Reset release through two flip-flops; assertion stays asynchronous.
    logic rst_meta_q;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    // Owner-disabled terms per pin, in register bit order.
    logic [N-1:0] unit_off;

    assign unit_off[sps_pkg::BIT_P1_RX - sps_pkg::FIRST_BIT]
        = ~port1_rx_en;
    assign unit_off[sps_pkg::BIT_P2_TX - sps_pkg::FIRST_BIT]
        = ~port2_tx_en;
    assign unit_off[sps_pkg::BIT_P2_RX - sps_pkg::FIRST_BIT]
        = ~port2_rx_en;
    assign unit_off[sps_pkg::BIT_P3_TX - sps_pkg::FIRST_BIT]
        = ~port3_tx_en;
    assign unit_off[sps_pkg::BIT_P3_RX - sps_pkg::FIRST_BIT]
        = ~port3_rx_en;
    assign unit_off[sps_pkg::BIT_P4_TX - sps_pkg::FIRST_BIT]
        = ~port4_tx_en;
    assign unit_off[sps_pkg::BIT_P4_RX - sps_pkg::FIRST_BIT]
        = ~port4_rx_en;
    assign unit_off[sps_pkg::BIT_P4_CLK - sps_pkg::FIRST_BIT]
        = ~port4_en;
    assign unit_off[sps_pkg::BIT_P4_FRAME - sps_pkg::FIRST_BIT]
        = ~port4_en;

    // A pin may carry the stored value only when its owner is off and the
    // direction says output; otherwise the write lands only in storage.
    logic [N-1:0] may_drive;

    assign may_drive = unit_off & pin_dir_out;

    // Bus handshake. The answer is given one cycle after the request is
    // seen, which keeps the read mux out of the pad-to-bus path.
    sps_pkg::sps_bus_st_t bus_st_q;
    sps_pkg::sps_bus_st_t bus_st_d;

    logic req;
    logic hit_state;
    logic accept;
    logic wr_accept;

    assign req       = read | write;
    assign hit_state = (address == sps_pkg::OFS_PIN_STATE);
    assign accept    = req && (bus_st_q == sps_pkg::BUS_ANSWER);
    assign wr_accept = accept && write && hit_state;

    always_comb begin
        bus_st_d = bus_st_q;
        case (bus_st_q)
            sps_pkg::BUS_IDLE: begin
                if (req) begin
                    bus_st_d = sps_pkg::BUS_ANSWER;
                end
            end
            sps_pkg::BUS_ANSWER: begin
                bus_st_d = sps_pkg::BUS_IDLE;
            end
            default: begin
                bus_st_d = sps_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bus_st_q <= sps_pkg::BUS_IDLE;
        end else begin
            bus_st_q <= bus_st_d;
        end
    end

    // During a request, waitrequest drops in the answer cycle only.
    assign waitrequest = req && (bus_st_q != sps_pkg::BUS_ANSWER);

    // Full 32-bit view of the write data and which bits the lanes allow.
    logic [31:0] lane_mask;

    assign lane_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                        {8{byteenable[1]}}, {8{byteenable[0]}}};

    // Per-pin storage, drive and live level.
    logic [N-1:0] level;
    logic [N-1:0] store;

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_pin
            localparam int B = sps_pkg::FIRST_BIT + gi;

            logic bit_wr;

            assign bit_wr = wr_accept & lane_mask[B];

            // Live pad level, filtered against metastability.
            sps_sync3 u_sync (
                .clk      (clk),
                .rst_n    (rst_sync_n),
                .async_in (pin_in[gi]),
                .level    (level[gi])
            );

            // Stored value and gated pad drive.
            sps_pin_cell u_cell (
                .clk       (clk),
                .rst_n     (rst_sync_n),
                .wr_en     (bit_wr),
                .wr_val    (writedata[B]),
                .may_drive (may_drive[gi]),
                .store     (store[gi]),
                .pin_out   (pin_out[gi]),
                .pin_oe    (pin_oe[gi])
            );
        end
    endgenerate

    // Reads return the live pad levels, not the stored values, so software
    // sees what the pad really carries; bits outside 13 to 21 read zero.
    logic [31:0] state_view;
    logic [31:0] read_mux;

    assign state_view = {{(31 - sps_pkg::BIT_P4_FRAME){1'b0}}, level,
                         {sps_pkg::FIRST_BIT{1'b0}}};
    assign read_mux   = hit_state ? state_view : sps_pkg::PIN_STATE_RST;

    // Read data is captured when the request is first seen and stands
    // through the answer cycle.
    logic [31:0] rdata_q;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata_q <= sps_pkg::PIN_STATE_RST;
        end else if (read && (bus_st_q == sps_pkg::BUS_IDLE)) begin
            rdata_q <= read_mux;
        end
    end

    assign readdata = rdata_q;

endmodule // sps_pin_state

`default_nettype wire

// ==== bench/sps_pad_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module sps_pad_model (
    // Slice drive and far device level.
    input  wire logic [8:0] pin_out,
    input  wire logic [8:0] pin_oe,
    input  wire logic [8:0] far_lvl,
    // Resolved pad level.
    output logic      [8:0] pad
);
    // The far device drives a pin only where the slice lets go of it.
    assign pad = (pin_oe & pin_out) | (~pin_oe & far_lvl);
endmodule // sps_pad_model
`default_nettype wire

// ==== bench/sps_pin_state_chk.sv ====
`timescale 1ns/1ps
`default_nettype none

module sps_pin_state_chk (
    // Clock, reset and bus.
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [3:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // Unit enables and pins.
    input wire logic        port1_rx_en,
    input wire logic        port2_tx_en,
    input wire logic        port2_rx_en,
    input wire logic        port3_tx_en,
    input wire logic        port3_rx_en,
    input wire logic        port4_tx_en,
    input wire logic        port4_rx_en,
    input wire logic        port4_en,
    input wire logic [8:0]  pin_dir_out,
    input wire logic [8:0]  pin_in,
    input wire logic [8:0]  pin_out,
    input wire logic [8:0]  pin_oe
);
    // Checks wait until the reset copy and the pin filters have settled.
    logic [3:0] age_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) age_q <= 4'h0;
        else if (age_q != 4'hF) age_q <= age_q + 4'h1;
    end
    // Settled flag, completed transfer and completed write to the word.
    wire logic live = age_q > 4'h8;
    wire logic done = (read | write) & ~waitrequest;
    wire logic acc0 = done & write & (address == 4'h0);
    wire logic [8:0] wbits = writedata[21:13];
    // Drive permission per pin, clock and frame both follow port4_en.
    wire logic [8:0] may = pin_dir_out & ~{port4_en, port4_en, port4_rx_en,
        port4_tx_en, port3_rx_en, port3_tx_en, port2_rx_en, port2_tx_en,
        port1_rx_en};
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_req; live && $rose(read | write); endsequence
    sequence s_quiet; $stable(pin_in) [*7]; endsequence
    chk_one_wait: assert property (s_req |-> waitrequest ##1 !waitrequest)
        else $error("bus wait is not one cycle");
    chk_idle_nowait: assert property (!(read | write) |-> !waitrequest)
        else $error("wait raised while idle");
    chk_oe_gate: assert property (live |-> pin_oe == $past(may))
        else $error("pin drive enable wrong");
    chk_write_lands: assert property (live && acc0 && byteenable == 4'hF
        |=> pin_out == $past(wbits))
        else $error("written level not stored");
    chk_lane_mask: assert property (live && acc0 && byteenable == 4'h2
        |=> ((pin_out ^ $past(pin_out)) & 9'h1F8) == 9'h000
        && ((pin_out ^ $past(wbits)) & 9'h007) == 9'h000)
        else $error("byte lane gating wrong");
    chk_out_holds: assert property (live && !acc0 |=> $stable(pin_out))
        else $error("stored level changed without write");
    chk_rd_zero: assert property (done && read |-> readdata[31:22] == 10'h000
        && readdata[12:0] == 13'h0000 && (address == 4'h0 || readdata == 32'h0))
        else $error("unused read bits not zero");
    chk_pad_echo: assert property (s_quiet ##0 live && done && read
        && address == 4'h0 |-> readdata[21:13] == pin_in)
        else $error("readback differs from pad level");
endmodule // sps_pin_state_chk
`default_nettype wire

// ==== bench/sps_pin_state_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module sps_pin_state_bench;
    typedef struct packed {
        logic [7:0] en;
        logic [8:0] dir;
        logic [8:0] wv;
        logic [8:0] oe;
    } sps_row_t;
    logic clk = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0;
    logic [3:0]  address = 4'h0, byteenable = 4'h0;
    logic [31:0] writedata = 32'h0, readdata, q;
    logic        waitrequest;
    logic [7:0]  en = 8'h00;
    logic [8:0]  pin_dir_out = 9'h000, far = 9'h000, pad, pin_out, pin_oe;
    int          n_fail = 0, check_count = 0;
    // Enables in order: p1 rx, p2 tx, p2 rx, p3 tx, p3 rx, p4 tx, p4 rx, p4.
    sps_row_t rows [6] = '{'{8'h00, 9'h1FF, 9'h1AB, 9'h1FF},
        '{8'hFF, 9'h1FF, 9'h155, 9'h000}, '{8'h00, 9'h000, 9'h0F0, 9'h000},
        '{8'h55, 9'h1FF, 9'h1FF, 9'h1AA}, '{8'hAA, 9'h1FF, 9'h0FF, 9'h055},
        '{8'h80, 9'h1FF, 9'h1C0, 9'h07F}};
    // Free-running system clock.
    always #10 clk = ~clk;
    sps_pin_state DUT (.clk(clk), .nrst(nrst), .address(address),
        .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .port1_rx_en(en[0]), .port2_tx_en(en[1]), .port2_rx_en(en[2]),
        .port3_tx_en(en[3]), .port3_rx_en(en[4]), .port4_tx_en(en[5]),
        .port4_rx_en(en[6]), .port4_en(en[7]), .pin_dir_out(pin_dir_out),
        .pin_in(pad), .pin_out(pin_out), .pin_oe(pin_oe));
    sps_pad_model U_PAD (.pin_out(pin_out), .pin_oe(pin_oe), .far_lvl(far),
        .pad(pad));
    task end_sim;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            $display("wrong value %s exp %h got %h", nm, e, s);
            n_fail++;
        end
    endtask
    // One bus access; the wait is bounded so a stuck slave ends the run.
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d,
             input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clk);
        address <= a; writedata <= d; byteenable <= b;
        write <= w; read <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 10);
        q = readdata;
        write <= 1'b0; read <= 1'b0;
        if (waitrequest !== 1'b0) begin
            n_fail++;
            end_sim();
        end
    endtask
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (10) @(posedge clk);
        foreach (rows[i]) begin
            en <= rows[i].en; pin_dir_out <= rows[i].dir; far <= ~rows[i].wv;
            bus(1'b1, 4'h0, {10'h0, rows[i].wv, 13'h0}, 4'hF);
            repeat (6) @(posedge clk);
            bus(1'b0, 4'h0, 32'h0, 4'h0);
            chk("readback", {10'h0, (rows[i].oe & rows[i].wv) |
                (~rows[i].oe & ~rows[i].wv), 13'h0}, q);
            chk("pin_oe", {23'h0, rows[i].oe}, {23'h0, pin_oe});
            chk("pin_out", {23'h0, rows[i].wv}, {23'h0, pin_out});
            $display("row %0d done", i);
        end
        bus(1'b1, 4'h0, 32'h003F_E000, 4'hF);
        bus(1'b1, 4'h0, 32'h0, 4'h2);
        @(negedge clk);
        chk("lane", 32'h1F8, {23'h0, pin_out});
        bus(1'b1, 4'h4, 32'h0, 4'hF);
        bus(1'b0, 4'h4, 32'h0, 4'h0);
        chk("unmapped", 32'h0, q);
        @(negedge clk);
        chk("kept", 32'h1F8, {23'h0, pin_out});
        // Lane 2 alone: bits 16 to 21 clear, bits 13 to 15 must stay 0.
        bus(1'b1, 4'h0, 32'h0000_E000, 4'h4);
        @(negedge clk);
        chk("lane2", 32'h0, {23'h0, pin_out});
        $display("lane and unmapped test done");
        @(posedge clk);
        nrst <= 1'b0;
        @(negedge clk);
        chk("reset", 32'h0, {14'h0, pin_oe, pin_out});
        chk("reset readdata", 32'h0, readdata);
        @(posedge clk);
        nrst <= 1'b1;
        repeat (10) @(posedge clk);
        // Port 4 still on: its clock and frame pins must stay undriven.
        chk("oe after reset", 32'h07F, {23'h0, pin_oe});
        $display("reset test done");
        end_sim();
    end
endmodule // sps_pin_state_bench

// The checker sees only the slice's own ports.
bind sps_pin_state sps_pin_state_chk u_chk (.clk(clk), .nrst(nrst),
    .address(address), .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .port1_rx_en(port1_rx_en), .port2_tx_en(port2_tx_en),
    .port2_rx_en(port2_rx_en), .port3_tx_en(port3_tx_en),
    .port3_rx_en(port3_rx_en), .port4_tx_en(port4_tx_en),
    .port4_rx_en(port4_rx_en), .port4_en(port4_en),
    .pin_dir_out(pin_dir_out), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe));
`default_nettype wire
